//--- rtl/intc_pkg.sv
// Purpose: shared constants and types of the interrupt merger.
// Assumes: single pclk domain, APB register access.
// Notes: behaviour summary follows.
// Behaviour
// - input 0 ranks highest, higher index lower
// - vector output follows highest-priority pending interrupt
// - async-flagged inputs pass 0-7 stage synchroniser
// - per-input edge (1) or level (0) sense
// - edge inputs: 1 rising, 0 falling
// - level inputs: 1 active high, 0 low
// - one to thirty-two hardware inputs, default one
// - request output edge (0) or level (1)
// - request output sense: 0 low, 1 high
// - absent features: logic gone, outputs constant
// - no cpu clock: request on bus clock
// - internal synchronisers selectable, default unused
// - zero to thirty-one software sources
// - vector output 32 to 64 bits wide
// - fast vectored logic optional, default absent
// - output connection bus (0) or single (1)
// - level register optional; others present by default
// - register bus: 9-bit address, 32-bit data
// - per-input flag vectors little-endian, bus wide
`default_nettype none

package intc_pkg;

  // ==========================================
  // Sizes
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned MAX_INPUTS = 32;
  localparam int unsigned MAX_SYNC = 7;
  localparam int unsigned VEC_MAX_W = 64;
  localparam int unsigned CPU_SYNC_STAGES = 2;

  // ==========================================
  // Build defaults
  localparam int unsigned DEF_NUM_INPUTS = 1;
  localparam int unsigned DEF_SYNC_STAGES = 2;
  localparam int unsigned DEF_SOFT_COUNT = 0;
  localparam int unsigned DEF_VEC_W = 32;
  localparam logic [31:0] DEF_ALL_ONES = 32'hFFFF_FFFF;

  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [8:0] OFS_STATUS = 9'h000;
  localparam logic [8:0] OFS_PENDING = 9'h004;
  localparam logic [8:0] OFS_ENABLE = 9'h008;
  localparam logic [8:0] OFS_ACK = 9'h00C;
  localparam logic [8:0] OFS_SET_EN = 9'h010;
  localparam logic [8:0] OFS_CLR_EN = 9'h014;
  localparam logic [8:0] OFS_VECTOR = 9'h018;
  localparam logic [8:0] OFS_MASTER = 9'h01C;
  localparam logic [8:0] OFS_LEVEL = 9'h024;
  localparam logic [1:0] OFS_VTAB_SEL = 2'h2;
  localparam logic [1:0] OFS_VTAB_HI_SEL = 2'h3;

  // ==========================================
  // Field positions and reset values
  localparam int unsigned MASTER_EN_BIT = 0;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_LEVEL = 32'hFFFF_FFFF;
  localparam logic [31:0] NO_VECTOR = 32'hFFFF_FFFF;

  // ==========================================
  // Processor acknowledge codes
  typedef enum logic [1:0] {
    ACK_NONE = 2'h0,
    ACK_BRANCH = 2'h1,
    ACK_RETURN = 2'h2,
    ACK_REENABLE = 2'h3
  } cpu_ack_type;

  // ==========================================
  // APB carriers
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic pwrite;
    logic [DATA_W-1:0] pwdata;
    logic psel;
    logic penable;
  } apb_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  // ==========================================
  // Whole block state
  typedef struct packed {
    logic [MAX_SYNC-1:0][MAX_INPUTS-1:0] sync;
    logic [MAX_INPUTS-1:0] prev;
    logic [MAX_INPUTS-1:0] status;
    logic [MAX_INPUTS-1:0] enable;
    logic [31:0] level;
    logic master;
    logic req_prev;
    logic irq_act;
    logic [CPU_SYNC_STAGES-1:0] cpu_pipe;
    logic [4:0] vec_idx;
    logic vec_ok;
    logic [MAX_INPUTS-1:0][VEC_MAX_W-1:0] vtab;
    logic [VEC_MAX_W-1:0] vec_addr;
    logic [DATA_W-1:0] rdata;
    logic rerr;
  } state_type;

  localparam state_type STATE_RST = '{
    sync: '0,
    prev: '0,
    status: '0,
    enable: RST_ENABLE,
    level: RST_LEVEL,
    master: 1'b0,
    req_prev: 1'b0,
    irq_act: 1'b0,
    cpu_pipe: '0,
    vec_idx: '0,
    vec_ok: 1'b0,
    vtab: '0,
    vec_addr: '0,
    rdata: '0,
    rerr: 1'b0
  };

endpackage

`default_nettype wire

//--- rtl/interrupt_merger.sv
// Purpose: build-time configurable interrupt merger with APB registers.
// Assumes: inputs and processor ack synchronous to pclk unless flagged.
// Notes: one state struct, one comb next-state, one register process.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module interrupt_merger #(
  parameter int unsigned num_inputs = intc_pkg::DEF_NUM_INPUTS,
  parameter int unsigned soft_source_count = intc_pkg::DEF_SOFT_COUNT,
  parameter logic [31:0] per_input_async_flags = intc_pkg::DEF_ALL_ONES,
  parameter int unsigned sync_stage_count = intc_pkg::DEF_SYNC_STAGES,
  parameter logic [31:0] per_input_sense_type = intc_pkg::DEF_ALL_ONES,
  parameter logic [31:0] per_input_edge_polarity = intc_pkg::DEF_ALL_ONES,
  parameter logic [31:0] per_input_level_polarity = intc_pkg::DEF_ALL_ONES,
  parameter bit output_level_style = 1'b1,
  parameter bit irq_active_high = 1'b1,
  parameter bit cpu_clock_absent = 1'b1,
  parameter bit sync_disabled = 1'b1,
  parameter bit fast_present = 1'b0,
  parameter bit irq_single = 1'b0,
  parameter bit nesting_level_present = 1'b0,
  parameter bit pending_view_present = 1'b1,
  parameter bit set_enable_present = 1'b1,
  parameter bit clear_enable_present = 1'b1,
  parameter bit vector_reg_present = 1'b1,
  parameter int unsigned vec_addr_w = intc_pkg::DEF_VEC_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire intc_pkg::apb_req_type apb_req,
  output var intc_pkg::apb_rsp_type apb_rsp,
  // Peripheral requests
  input wire logic [intc_pkg::MAX_INPUTS-1:0] intr_in,
  // Processor side
  input wire intc_pkg::cpu_ack_type processor_ack,
  output logic irq,
  output logic [vec_addr_w-1:0] vector_addr
);
  import intc_pkg::*;

  // ==========================================
  // Derived build settings
  // Fast vectoring needs bus-style connection
  localparam bit FAST_ON = fast_present && !irq_single;
  // Cpu-side delay only with its own clock and synchronisers on
  localparam bit CPU_SYNC_ON = !cpu_clock_absent && !sync_disabled;
  localparam int unsigned STG_IDX = (sync_stage_count == 0) ? 0 : sync_stage_count - 1;

  state_type s;
  state_type n;

  logic [MAX_INPUTS-1:0] samp;
  logic [MAX_INPUTS-1:0] hit;
  logic [MAX_INPUTS-1:0] hw_mask;
  logic [MAX_INPUTS-1:0] soft_mask;
  logic [MAX_INPUTS-1:0] lvl_ok;
  logic [MAX_INPUTS-1:0] pending;
  logic [4:0] top_idx;
  logic top_ok;
  logic req;
  logic setup_ph;
  logic access_ph;
  logic [1:0] ofs_sel;
  logic [4:0] vtab_idx;
  logic irq_core;

  // ==========================================
  // Per-input conditioning
  for (genvar g = 0; g < MAX_INPUTS; g++) begin : g_in
    if (g < num_inputs) begin : g_hw
      // Async inputs read the last synchroniser stage
      assign samp[g] = (per_input_async_flags[g] && sync_stage_count != 0) ?
                       s.sync[STG_IDX][g] : intr_in[g];
      // Edge or level detection, per-input polarity
      assign hit[g] = per_input_sense_type[g] ?
                      (per_input_edge_polarity[g] ? (samp[g] & ~s.prev[g])
                                                  : (~samp[g] & s.prev[g]))
                      : (samp[g] == per_input_level_polarity[g]);
      assign hw_mask[g] = 1'b1;
    end else begin : g_off
      // Unused input ports ignored
      assign samp[g] = 1'b0;
      assign hit[g] = 1'b0;
      assign hw_mask[g] = 1'b0;
    end
    // Software sources sit just above the hardware inputs
    assign soft_mask[g] = (g >= num_inputs) && (g < num_inputs + soft_source_count);
    // Nesting level lets only indices below it through
    assign lvl_ok[g] = (32'(g) < s.level);
  end

  // ==========================================
  // Merge and priority
  assign pending = s.status & s.enable & lvl_ok & (hw_mask | soft_mask);
  assign req = s.master & (|pending);

  // Lowest index wins
  always_comb begin
    top_idx = 5'h00;
    top_ok = 1'b0;
    for (int k = MAX_INPUTS - 1; k >= 0; k--) begin
      if (pending[k]) begin
        top_idx = 5'(k);
        top_ok = 1'b1;
      end
    end
  end

  // ==========================================
  // Bus decode
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable;
  assign ofs_sel = apb_req.paddr[8:7];
  assign vtab_idx = apb_req.paddr[6:2];

  // ==========================================
  // Next state
  always_comb begin
    logic [MAX_INPUTS-1:0] clr;
    logic [MAX_INPUTS-1:0] sw_set;
    logic wr;
    logic [DATA_W-1:0] rd;
    logic bad;
    clr = '0;
    sw_set = '0;
    wr = access_ph & apb_req.pwrite;
    rd = '0;
    bad = 1'b0;
    n = s;

    // Synchroniser shift chain
    n.sync[0] = intr_in;
    for (int k = 1; k < MAX_SYNC; k++) begin
      n.sync[k] = s.sync[k-1];
    end
    n.prev = samp;

    // Register writes
    if (wr && apb_req.paddr[1:0] == 2'h0) begin
      if (ofs_sel == OFS_VTAB_SEL) begin
        if (FAST_ON) begin
          n.vtab[vtab_idx][31:0] = apb_req.pwdata;
        end
      end else if (ofs_sel == OFS_VTAB_HI_SEL) begin
        if (FAST_ON && vec_addr_w > DATA_W) begin
          n.vtab[vtab_idx][63:32] = apb_req.pwdata;
        end
      end else begin
        case (apb_req.paddr)
          OFS_STATUS: sw_set = apb_req.pwdata & soft_mask;
          OFS_ENABLE: n.enable = apb_req.pwdata & (hw_mask | soft_mask);
          OFS_ACK: clr = apb_req.pwdata;
          OFS_SET_EN: begin
            if (set_enable_present) begin
              n.enable = s.enable | (apb_req.pwdata & (hw_mask | soft_mask));
            end
          end
          OFS_CLR_EN: begin
            if (clear_enable_present) begin
              n.enable = s.enable & ~apb_req.pwdata;
            end
          end
          OFS_MASTER: n.master = apb_req.pwdata[MASTER_EN_BIT];
          OFS_LEVEL: begin
            if (nesting_level_present) begin
              n.level = apb_req.pwdata;
            end
          end
          default: ;
        endcase
      end
    end

    // Processor branch ack clears the vectored source
    if (FAST_ON && processor_ack == ACK_BRANCH && s.vec_ok) begin
      clr[s.vec_idx] = 1'b1;
    end

    // Sticky status, a fresh event beats a clear
    n.status = ((s.status & ~clr) | hit | sw_set) & (hw_mask | soft_mask);

    // Request output, level or one-cycle edge
    n.req_prev = req;
    n.irq_act = output_level_style ? req : (req & ~s.req_prev);
    n.cpu_pipe = {s.cpu_pipe[CPU_SYNC_STAGES-2:0], s.irq_act};

    // Vector of the highest-priority interrupt
    n.vec_idx = top_idx;
    n.vec_ok = top_ok;
    n.vec_addr = FAST_ON ? s.vtab[top_idx] : '0;

    // Read data captured in setup phase
    if (setup_ph) begin
      if (apb_req.paddr[1:0] != 2'h0) begin
        bad = 1'b1;
      end else if (ofs_sel == OFS_VTAB_SEL) begin
        rd = FAST_ON ? s.vtab[vtab_idx][31:0] : '0;
        bad = !FAST_ON;
      end else if (ofs_sel == OFS_VTAB_HI_SEL) begin
        rd = (FAST_ON && vec_addr_w > DATA_W) ? s.vtab[vtab_idx][63:32] : '0;
        bad = !(FAST_ON && vec_addr_w > DATA_W);
      end else begin
        case (apb_req.paddr)
          OFS_STATUS: rd = s.status;
          OFS_PENDING: rd = pending_view_present ? (pending & {32{s.master}}) : '0;
          OFS_ENABLE: rd = s.enable;
          OFS_ACK: rd = '0;
          OFS_SET_EN: rd = '0;
          OFS_CLR_EN: rd = '0;
          OFS_VECTOR: begin
            if (vector_reg_present) begin
              rd = top_ok ? {27'h000_0000, top_idx} : NO_VECTOR;
            end
          end
          OFS_MASTER: rd = {31'h0000_0000, s.master};
          OFS_LEVEL: begin
            rd = nesting_level_present ? s.level : '0;
            bad = !nesting_level_present;
          end
          default: bad = 1'b1;
        endcase
      end
      n.rdata = rd;
      n.rerr = bad;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================
  // Outputs
  // Optional extra stages toward the processor
  assign irq_core = CPU_SYNC_ON ? s.cpu_pipe[CPU_SYNC_STAGES-1] : s.irq_act;
  // Active sense applied last
  assign irq = irq_active_high ? irq_core : ~irq_core;
  // Vector held at zero without fast logic
  assign vector_addr = s.vec_addr[vec_addr_w-1:0];
  // Zero-wait slave, registered data
  assign apb_rsp = '{prdata: s.rdata, pready: 1'b1, pslverr: s.rerr & access_ph};

endmodule

`default_nettype wire

//--- tb/cpu_model.sv
// Purpose: processor stand-in that watches the request output.
// Assumes: one pclk domain, ack code ignored while fast logic is absent.
// Notes: answers branch code for one cycle per new request.
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request in, handshake out
  input wire logic irq,
  output var intc_pkg::cpu_ack_type processor_ack
);
  import intc_pkg::*;
  logic irq_r;

  // ====
  // Branch code one cycle after a rise, none otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
      processor_ack <= ACK_NONE;
    end else begin
      irq_r <= irq;
      processor_ack <= (irq && !irq_r) ? ACK_BRANCH : ACK_NONE;
    end
  end
endmodule

`default_nettype wire

//--- tb/merger_checker.sv
// Purpose: port-level checks of the interrupt merger.
// Assumes: fast logic and level register absent.
// Notes: bound into every merger instance.
`timescale 1ns/1ps
`default_nettype none

module merger_checker #(
  parameter int unsigned vec_addr_w = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire intc_pkg::apb_req_type apb_req,
  input wire intc_pkg::apb_rsp_type apb_rsp,
  input wire logic [intc_pkg::MAX_INPUTS-1:0] intr_in,
  input wire intc_pkg::cpu_ack_type processor_ack,
  input wire logic irq,
  input wire logic [vec_addr_w-1:0] vector_addr
);
  import intc_pkg::*;
  logic acc;

  // ====
  // Access phase of a transfer
  assign acc = apb_req.psel && apb_req.penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_tied_a: assert property (apb_rsp.pready) else $error("pready low");
  err_in_access_a: assert property (apb_rsp.pslverr |-> acc) else $error("stray pslverr");
  misalign_err_a: assert property (acc && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr)
    else $error("misaligned access accepted");
  vtab_err_a: assert property (acc && apb_req.paddr[8] |-> apb_rsp.pslverr)
    else $error("vector table answered");
  level_err_a: assert property (acc && apb_req.paddr == OFS_LEVEL |-> apb_rsp.pslverr)
    else $error("level register answered");
  enable_ok_a: assert property (acc && apb_req.paddr == OFS_ENABLE |-> !apb_rsp.pslverr)
    else $error("enable access refused");
  vec_const_a: assert property (vector_addr == '0) else $error("vector output moved");
  rdata_hold_a: assert property (acc |=> $stable(apb_rsp.prdata)) else $error("prdata changed");
endmodule

bind interrupt_merger merger_checker #(.vec_addr_w(vec_addr_w)) u_chk (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .intr_in(intr_in), .processor_ack(processor_ack), .irq(irq),
  .vector_addr(vector_addr));

`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench of the interrupt merger.
// Assumes: four inputs: rising, falling, high (async), low; an edge-style twin.
// Notes: APB answers taken at the rising edge, irq polled at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import intc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  logic [31:0] intr_in = 32'h0000_000A;
  cpu_ack_type processor_ack;
  logic irq;
  logic [31:0] vector_addr;
  apb_rsp_type apb_rsp_edge;
  logic irq_edge;
  logic [31:0] vector_edge;
  int n_pulse = 0;
  int n_fail = 0;
  int samples_checked = 0;

  // ====
  // Clock, device and processor
  always #20 pclk = ~pclk;
  interrupt_merger #(.num_inputs(4), .per_input_async_flags(32'h0000_0004), .per_input_sense_type(32'h0000_0003),
    .per_input_edge_polarity(32'h0000_0001), .per_input_level_polarity(32'h0000_0004)) u_dut (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .intr_in(intr_in), .processor_ack(processor_ack),
    .irq(irq), .vector_addr(vector_addr));
  cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .processor_ack(processor_ack));
  // Edge-style, active-low twin on the same bus and inputs
  interrupt_merger #(.num_inputs(4), .per_input_async_flags(32'h0000_0004), .per_input_sense_type(32'h0000_0003),
    .per_input_edge_polarity(32'h0000_0001), .per_input_level_polarity(32'h0000_0004), .output_level_style(1'b0),
    .irq_active_high(1'b0)) u_dut_edge (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp_edge),
    .intr_in(intr_in), .processor_ack(processor_ack), .irq(irq_edge), .vector_addr(vector_edge));
  // Count cycles in which the twin's request is active
  always @(posedge pclk) begin
    if (presetn && irq_edge === 1'b0) begin
      n_pulse <= n_pulse + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer, answer taken at the completing edge
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        print_verdict();
      end
      @(posedge pclk);
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
    check("write error", 32'h0000_0000, {31'h0, e});
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] q;
    logic e;
    xfer(1'b0, a, 32'h0000_0000, q, e);
    check($sformatf("read %h", a), exp, q);
    check("read error", {31'h0, exp_e}, {31'h0, e});
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    for (n = 0; n < 12 && irq !== exp; n++) @(negedge pclk);
    check("irq", {31'h0, exp}, {31'h0, irq});
    if (irq !== exp) begin
      print_verdict();
    end
  endtask

  task automatic drive(input logic [31:0] v);
    @(posedge pclk);
    intr_in <= v;
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(OFS_ENABLE, 32'h0000_0000, 1'b0);
    wr(OFS_ENABLE, 32'h0000_000F);
    rd(OFS_LEVEL, 32'h0000_0000, 1'b1);
    rd(9'h020, 32'h0000_0000, 1'b1);
    rd(9'h104, 32'h0000_0000, 1'b1);
    xfer(1'b1, 9'h00A, 32'h0000_0000, q, e);
    check("misaligned error", 32'h0000_0001, {31'h0, e});
    rd(OFS_ENABLE, 32'h0000_000F, 1'b0);
    check("vector_addr", 32'h0000_0000, vector_addr);
    $display("t_regs done");
  endtask

  task automatic t_prio();
    wr(OFS_MASTER, 32'h0000_0001);
    drive(32'h0000_0004);
    wait_irq(1'b1);
    rd(OFS_STATUS, 32'h0000_000E, 1'b0);
    rd(OFS_VECTOR, 32'h0000_0001, 1'b0);
    wr(OFS_ACK, 32'h0000_0006);
    rd(OFS_STATUS, 32'h0000_000C, 1'b0);
    rd(OFS_VECTOR, 32'h0000_0002, 1'b0);
    drive(32'h0000_000A);
    wr(OFS_ACK, 32'h0000_000C);
    rd(OFS_STATUS, 32'h0000_0000, 1'b0);
    rd(OFS_VECTOR, 32'hFFFF_FFFF, 1'b0);
    wait_irq(1'b0);
    drive(32'h0000_003B);
    drive(32'h0000_000A);
    wait_irq(1'b1);
    rd(OFS_STATUS, 32'h0000_0001, 1'b0);
    rd(OFS_PENDING, 32'h0000_0001, 1'b0);
    rd(OFS_VECTOR, 32'h0000_0000, 1'b0);
    wr(OFS_MASTER, 32'h0000_0000);
    wait_irq(1'b0);
    rd(OFS_PENDING, 32'h0000_0000, 1'b0);
    wr(OFS_MASTER, 32'h0000_0001);
    wr(OFS_CLR_EN, 32'h0000_0001);
    rd(OFS_ENABLE, 32'h0000_000E, 1'b0);
    wait_irq(1'b0);
    wr(OFS_SET_EN, 32'h0000_0001);
    wait_irq(1'b1);
    wr(OFS_ACK, 32'h0000_0001);
    wait_irq(1'b0);
    check("edge pulses", 32'h0000_0004, n_pulse);
    $display("t_prio done");
  endtask

  // ====
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check("irq in reset", 32'h0000_0000, {31'h0, irq});
    check("twin irq in reset", 32'h0000_0001, {31'h0, irq_edge});
    t_regs();
    t_prio();
    print_verdict();
  end
endmodule

`default_nettype wire
